// file: pkg/usr_pkg.sv
// Constants, types and register map of the synchronous slave receiver.
package usr_pkg;

  // ==========================================================================
  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_RX_STATUS = 8'h00;
  localparam logic [7:0] OFS_TX_STATUS = 8'h04;
  localparam logic [7:0] OFS_RX_BUFFER = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // ==========================================================================
  // Field positions.
  localparam int RXS_PORT_EN = 7;
  localparam int RXS_NINTH_EN = 6;
  localparam int RXS_SINGLE_EN = 5;
  localparam int RXS_CONT_EN = 4;
  localparam int RXS_OERR = 1;
  localparam int RXS_NINTH_BIT = 0;
  localparam int TXS_CLK_SRC = 7;
  localparam int TXS_SYNC = 4;
  localparam int IRQ_RX = 0;

  // ==========================================================================
  // Word lengths, vector and pin reset level.
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [15:0] IRQ_VECTOR = 16'h0020;
  localparam logic PIN_RST_LVL = 1'b0;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } usr_rx_st_e;

  typedef struct packed {
    usr_rx_st_e fsm;
    logic [3:0] bit_cnt;
    logic [8:0] shr;
    logic [8:0] rbuf;
    logic rflag;
    logic oerr;
    logic port_en;
    logic ninth_en;
    logic single_en;
    logic cont_en;
    logic clk_src;
    logic sync;
    logic istat;
    logic imask;
    logic ack;
    logic [31:0] dat;
    logic irq;
    logic wake;
    logic branch;
    logic [15:0] vec;
    logic pin_o;
    logic pin_oe;
  } usr_rx_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
    logic fall;
  } usr_sync_s;

endpackage

// file: pkg/usr_pin_if.sv
// Carrier for one synchronised pin: filtered level and falling-edge pulse.
`timescale 1ns/1ps
`default_nettype none
interface usr_pin_if;
  logic lvl;
  logic fall;
  modport src (output lvl, output fall);
  modport dst (input lvl, input fall);
endinterface
`default_nettype wire

// file: hw/usr_pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge detect.
`timescale 1ns/1ps
`default_nettype none
module usr_pin_sync (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic pin_i,
  usr_pin_if.src pin
);

  // ==========================================================================
  // State.
  localparam usr_pkg::usr_sync_s RST_S = '{lvl: usr_pkg::PIN_RST_LVL, s1: usr_pkg::PIN_RST_LVL,
    s2: usr_pkg::PIN_RST_LVL, s3: usr_pkg::PIN_RST_LVL, fall: 1'b0};
  usr_pkg::usr_sync_s q;
  usr_pkg::usr_sync_s n;

  // The first stage feeds only the second; the filter looks at stages two and three.
  always_comb begin
    n = q;
    n.s1 = pin_i;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.fall = 1'b0;
    if (q.s2 == q.s3) begin
      n.lvl = q.s3;
      n.fall = q.lvl & ~q.s3;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= RST_S;
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign pin.lvl = q.lvl;
  assign pin.fall = q.fall;

endmodule
`default_nettype wire

// file: hw/usr_sync_rx.sv
// Synchronous slave receiver with classic Wishbone register slave.
`timescale 1ns/1ps
`default_nettype none
module usr_sync_rx (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ck_i,
  output logic ck_o,
  output logic ck_oe_o,
  input wire logic rx_data_i,
  input wire logic core_halt_i,
  input wire logic global_irq_en_i,
  output logic irq_o,
  output logic wake_o,
  output logic branch_o,
  output logic [15:0] vector_o
);

  // ==========================================================================
  // Pin synchronisers.
  usr_pin_if ck_if ();
  usr_pin_if dat_if ();

  usr_pin_sync u_ck_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .pin_i(ck_i),
    .pin(ck_if.src)
  );

  usr_pin_sync u_dat_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .pin_i(rx_data_i),
    .pin(dat_if.src)
  );

  // ==========================================================================
  // State.
  localparam usr_pkg::usr_rx_s RST_S = '{fsm: usr_pkg::ST_IDLE, default: '0};
  usr_pkg::usr_rx_s q;
  usr_pkg::usr_rx_s n;

  logic req;
  logic rx_en;
  logic last_bit;
  logic word_done;
  logic [8:0] word_w;
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      usr_pkg::OFS_RX_STATUS: begin
        rd_mux[usr_pkg::RXS_PORT_EN] = q.port_en;
        rd_mux[usr_pkg::RXS_NINTH_EN] = q.ninth_en;
        rd_mux[usr_pkg::RXS_SINGLE_EN] = q.single_en;
        rd_mux[usr_pkg::RXS_CONT_EN] = q.cont_en;
        rd_mux[usr_pkg::RXS_OERR] = q.oerr;
        rd_mux[usr_pkg::RXS_NINTH_BIT] = q.ninth_en & q.rbuf[8];
      end
      usr_pkg::OFS_TX_STATUS: begin
        rd_mux[usr_pkg::TXS_CLK_SRC] = q.clk_src;
        rd_mux[usr_pkg::TXS_SYNC] = q.sync;
      end
      usr_pkg::OFS_RX_BUFFER: begin
        rd_mux[7:0] = q.rbuf[7:0];
      end
      usr_pkg::OFS_IRQ_STAT: begin
        rd_mux[usr_pkg::IRQ_RX] = q.istat;
      end
      usr_pkg::OFS_IRQ_MASK: begin
        rd_mux[usr_pkg::IRQ_RX] = q.imask;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  // The receiver has no clock of its own here, so it only listens when the master clocks.
  assign rx_en = q.sync & q.port_en & ~q.clk_src & q.cont_en;
  assign last_bit = q.bit_cnt == (q.ninth_en ? usr_pkg::LAST_BIT_9 : usr_pkg::LAST_BIT_8);
  assign word_done = rx_en & ck_if.fall & last_bit;
  assign word_w = {dat_if.lvl, q.shr[8:1]};
  assign req = wb_cyc_i & wb_stb_i;

  always_comb begin
    n = q;
    n.pin_o = 1'b0;
    n.pin_oe = 1'b0;
    // ========================================================================
    // Bus: answer one cycle after the request, side effects at the edge that sees ack.
    n.ack = 1'b0;
    if (req && !q.ack) begin
      n.ack = 1'b1;
      n.dat = rd_mux;
    end
    if (req && q.ack) begin
      if (wb_we_i && wb_sel_i[0]) begin
        unique case (wb_adr_i)
          usr_pkg::OFS_RX_STATUS: begin
            n.port_en = wb_dat_i[usr_pkg::RXS_PORT_EN];
            n.ninth_en = wb_dat_i[usr_pkg::RXS_NINTH_EN];
            n.single_en = wb_dat_i[usr_pkg::RXS_SINGLE_EN];
            n.cont_en = wb_dat_i[usr_pkg::RXS_CONT_EN];
            if (!wb_dat_i[usr_pkg::RXS_CONT_EN]) begin
              n.oerr = 1'b0;
            end
          end
          usr_pkg::OFS_TX_STATUS: begin
            n.clk_src = wb_dat_i[usr_pkg::TXS_CLK_SRC];
            n.sync = wb_dat_i[usr_pkg::TXS_SYNC];
          end
          usr_pkg::OFS_IRQ_MASK: begin
            n.imask = wb_dat_i[usr_pkg::IRQ_RX];
          end
          default: begin
            n.imask = q.imask;
          end
        endcase
      end else if (!wb_we_i) begin
        if (wb_adr_i == usr_pkg::OFS_RX_BUFFER) begin
          n.rflag = 1'b0;
        end
        if (wb_adr_i == usr_pkg::OFS_IRQ_STAT) begin
          n.istat = 1'b0;
        end
      end
    end
    // ========================================================================
    // Shifter: the core halt input does not reach this logic, so words still arrive while halted.
    if (!rx_en) begin
      n.fsm = usr_pkg::ST_IDLE;
      n.bit_cnt = 4'h0;
      n.shr = 9'h000;
    end else if (ck_if.fall) begin
      n.shr = word_w;
      if (last_bit) begin
        n.fsm = usr_pkg::ST_IDLE;
        n.bit_cnt = 4'h0;
        n.istat = 1'b1;
        // A word that finds the buffer full is dropped; the old word is kept for software.
        if (n.rflag) begin
          n.oerr = 1'b1;
        end else begin
          n.rbuf = q.ninth_en ? word_w : {1'b0, word_w[8:1]};
          n.rflag = 1'b1;
        end
      end else begin
        n.fsm = usr_pkg::ST_SHIFT;
        n.bit_cnt = q.bit_cnt + 4'h1;
      end
    end
    // ========================================================================
    // Interrupt, wake and vector.
    n.irq = n.istat & n.imask;
    n.wake = n.irq & core_halt_i;
    n.branch = n.irq & global_irq_en_i;
    n.vec = n.branch ? usr_pkg::IRQ_VECTOR : 16'h0000;
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= RST_S;
    end else if (ce_i) begin
      q <= n;
    end
  end

  assign wb_dat_o = q.dat;
  assign wb_ack_o = q.ack;
  assign ck_o = q.pin_o;
  assign ck_oe_o = q.pin_oe;
  assign irq_o = q.irq;
  assign wake_o = q.wake;
  assign branch_o = q.branch;
  assign vector_o = q.vec;

  // ==========================================================================
  // Assertions.
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_rbuf_read;
    ce_i && req && !wb_we_i && wb_adr_i == usr_pkg::OFS_RX_BUFFER && !q.ack ##1 q.ack;
  endsequence

  sequence s_word_end;
    ce_i && word_done && !q.rflag;
  endsequence

  a_ack_single: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_clock_never_driven: assert property (!ck_oe_o)
    else $error("serial timing pin driven");
  a_mode_gate: assert property (ce_i && (q.clk_src || !q.sync || !q.port_en) |=> q.fsm == usr_pkg::ST_IDLE)
    else $error("receiver active outside slave mode");
  a_flag_on_word: assert property (s_word_end |=> q.rflag && q.istat)
    else $error("word end did not set the receive flag");
  a_irq_raise: assert property (ce_i && !q.istat ##1 q.istat && q.imask |-> irq_o)
    else $error("unmasked receive event gave no interrupt");
  a_wake_halt: assert property (ce_i && core_halt_i && n.irq |=> wake_o)
    else $error("halted core not woken");
  a_vector_addr: assert property (branch_o |-> vector_o == 16'h0020)
    else $error("wrong interrupt vector");
  a_word_length: assert property (word_done |-> q.bit_cnt == (q.ninth_en ? 4'h8 : 4'h7))
    else $error("word ended at the wrong bit count");
  a_rbuf_low: assert property (s_rbuf_read |-> wb_dat_o[7:0] == $past(q.rbuf[7:0]) && wb_dat_o[31:8] == 24'h0)
    else $error("receive buffer read returned wrong data");
  a_err_clear: assert property ($fell(q.cont_en) |-> !q.oerr)
    else $error("error not cleared with continuous receive");
  a_abort_idle: assert property (ce_i && !rx_en |=> q.bit_cnt == 4'h0 && q.fsm == usr_pkg::ST_IDLE)
    else $error("receiver not idle after abort");

endmodule
`default_nettype wire

// file: bench/usr_ser_master.sv
// Behavioural serial master that drives the shift clock and data into the receiver.
`timescale 1ns/1ps
`default_nettype none
module usr_ser_master (
  output logic ck_o,
  output logic dat_o
);
  initial begin
    ck_o = 1'b1;
    dat_o = 1'b1;
  end
  // Bits go LSB first, one per shift clock period, set a half period before the fall.
  // The clock stands high between frames; slow stretches the high half.
  task automatic send(input logic [8:0] w, input int n, input int slow);
    #3;
    for (int i = 0; i < n; i++) begin
      dat_o = w[i];
      #(80 + slow) ck_o = 1'b0;
      #80 ck_o = 1'b1;
    end
    // The line does not keep the last bit once the frame is over.
    dat_o = ~w[n-1];
  endtask
endmodule
`default_nettype wire

// file: bench/tb_usart_sync_slave_receiver.sv
// Self-checking bench of the synchronous slave receiver.
`timescale 1ns/1ps
`default_nettype none
module tb_usart_sync_slave_receiver;
  localparam logic [7:0] RS = usr_pkg::OFS_RX_STATUS;
  localparam logic [7:0] TS = usr_pkg::OFS_TX_STATUS;
  localparam logic [7:0] RB = usr_pkg::OFS_RX_BUFFER;
  localparam logic [7:0] IS = usr_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] IM = usr_pkg::OFS_IRQ_MASK;
  typedef struct {logic [7:0] cfg; logic [8:0] w;} usr_row_s;
  logic mclk_i, rst_b_i, cyc, we, ack, ck, sd, halt, gie, irq, wake, br, ck_o, ck_oe;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [15:0] vec;
  int num_errors = 0;
  int checked = 0;
  usr_row_s rows [5] = '{'{8'h90, 9'h000}, '{8'h90, 9'h0ff}, '{8'hb0, 9'h0a5}, '{8'hd0, 9'h13c}, '{8'hd0, 9'h0c3}};

  usr_sync_rx uut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ck_i(ck), .ck_o(ck_o),
    .ck_oe_o(ck_oe), .rx_data_i(sd), .core_halt_i(halt), .global_irq_en_i(gie), .irq_o(irq), .wake_o(wake),
    .branch_o(br), .vector_o(vec));
  usr_ser_master mst (.ck_o(ck), .dat_o(sd));

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  // ==========================================================================
  // Bus and check helpers.
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // The request is held until ack is seen high, so a slow answer is waited out, not assumed.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      num_errors++;
      report_and_stop();
    end
    q = rdat;
    cyc <= 1'b0;
    we <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 100) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 100) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  initial begin
    #500us;
    num_errors++;
    report_and_stop();
  end

  // ==========================================================================
  // Main sequence.
  initial begin
    {rst_b_i, cyc, we, halt, gie} = 5'h0;
    adr = 8'h00;
    wdat = 32'h0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk({27'h0, irq, wake, br, ck_o, ck_oe}, 32'h0);
    chk({16'h0, vec}, 32'h0);
    rd(RS, 32'h0);
    rd(8'h14, 32'h0);
    wb(1'b1, TS, 32'h10);
    wb(1'b1, IM, 32'h1);
    foreach (rows[i]) begin
      wb(1'b1, RS, {24'h0, rows[i].cfg});
      mst.send(rows[i].w, rows[i].cfg[6] ? 9 : 8, 0);
      wait_irq();
      chk({30'h0, wake, br}, 32'h0);
      rd(IS, 32'h1);
      rd(RS, {24'h0, rows[i].cfg | {7'h0, rows[i].cfg[6] & rows[i].w[8]}});
      rd(RB, {24'h0, rows[i].w[7:0]});
      rd(IS, 32'h0);
    end
    // Halted core with a slow master: the word must still land and wake the core.
    wb(1'b1, RS, 32'h90);
    halt <= 1'b1;
    gie <= 1'b1;
    mst.send(9'h069, 8, 40);
    wait_irq();
    chk({29'h0, wake, br, irq}, 32'h7);
    chk({16'h0, vec}, 32'h20);
    rd(RB, 32'h69);
    rd(IS, 32'h1);
    halt <= 1'b0;
    gie <= 1'b0;
    // A second word while the first is unread gives an overrun that only a cleared enable removes.
    mst.send(9'h011, 8, 0);
    wait_irq();
    rd(IS, 32'h1);
    mst.send(9'h022, 8, 0);
    wait_irq();
    rd(RS, 32'h92);
    wb(1'b1, RS, 32'h80);
    rd(RS, 32'h80);
    rd(RB, 32'h11);
    rd(IS, 32'h1);
    // Half a word, then the port is switched off and on again.
    wb(1'b1, RS, 32'h90);
    mst.send(9'h00f, 4, 0);
    wb(1'b1, RS, 32'h10);
    wb(1'b1, RS, 32'h90);
    mst.send(9'h05a, 8, 0);
    wait_irq();
    rd(RB, 32'h5a);
    rd(IS, 32'h1);
    // Master clock mode selected: the slave receiver must stay quiet.
    wb(1'b1, TS, 32'h90);
    mst.send(9'h033, 8, 0);
    repeat (20) @(posedge mclk_i);
    rd(IS, 32'h0);
    wb(1'b1, TS, 32'h10);
    wb(1'b1, IM, 32'h0);
    mst.send(9'h044, 8, 0);
    repeat (20) @(posedge mclk_i);
    chk({31'h0, irq}, 32'h0);
    rd(IS, 32'h1);
    rd(RB, 32'h44);
    // Single receive enable alone must not open the receiver in slave mode.
    wb(1'b1, RS, 32'ha0);
    mst.send(9'h055, 8, 0);
    repeat (20) @(posedge mclk_i);
    rd(IS, 32'h0);
    // Reset in mid-run: the three status registers return to zero and the outputs fall.
    rst_b_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    chk({27'h0, irq, wake, br, ck_o, ck_oe}, 32'h0);
    rd(RS, 32'h0);
    rd(TS, 32'h0);
    rd(IS, 32'h0);
    report_and_stop();
  end
endmodule
`default_nettype wire
